/* rtl/lrb_top.sv */
// Rating blocking output and filtered extended data recovery
`timescale 1ns/1ps
module lrb_top (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Line 21 pairs from the slicer
  input  wire logic             i_l21_valid,
  input  wire logic             i_l21_field2,
  input  wire lrb_pkg::lrb_pair_t i_l21_pair,
  // Video timing and tuner events
  input  wire logic             i_frame_tick,
  input  wire logic             i_chan_change,
  // Command bytes from the serial port
  input  wire logic             i_cmd_valid,
  input  wire logic       [7:0] i_cmd_byte,
  input  wire logic             i_out_read,
  // Serial output registers and status flags
  output logic            [7:0] o_out_byte0,
  output logic            [7:0] o_out_byte1,
  output logic                  o_pair_ready_flag,
  output logic                  o_two_byte_flag,
  // Blocking pin
  output logic                  o_block
);

  lrb_pkg::lrb_cmd_state_t cmd_state_reg;
  logic [3:0]              wr_addr_reg;
  logic [7:0]              filter_reg;
  logic [7:0]              movie_mask_reg;
  logic [7:0]              tv_base_reg;
  logic [7:0]              tv_sv_reg;
  logic [7:0]              tv_dl_reg;
  logic [7:0]              blk_ctrl_reg;
  lrb_pkg::lrb_rating_t    rating_reg;
  logic                    match_reg;
  logic [6:0]              ext_cnt_reg;
  logic                    in_xds_reg;
  logic                    pass_reg;
  logic [2:0]              cls_reg;
  logic                    rate_pkt_reg;
  logic [6:0]              c0;
  logic [6:0]              c1;
  logic [2:0]              cls_now;
  logic                    is_xds_ctrl;
  logic                    is_start;
  logic                    is_end;
  logic                    is_cc;
  logic                    pass_now;
  logic                    emit;
  logic                    xds_load;
  logic                    rate_cap;
  logic                    cmd_wr;
  logic                    cmd_rds;
  logic                    blk_en;
  logic                    block_next;
  logic [7:0]              sec_ctx;

  // Register read mux; reserved addresses read zero
  function automatic logic [7:0] reg_read(input logic [3:0] a);
    unique case (a)
      lrb_pkg::REG_FILTER:     reg_read = filter_reg;
      lrb_pkg::REG_MOVIE_MASK: reg_read = movie_mask_reg;
      lrb_pkg::REG_TV_BASE:    reg_read = tv_base_reg;
      lrb_pkg::REG_TV_SV:      reg_read = tv_sv_reg;
      lrb_pkg::REG_TV_DL:      reg_read = tv_dl_reg;
      lrb_pkg::REG_STAT1:      reg_read = {match_reg, rating_reg.first};      // [RQ6] [RQ7]
      lrb_pkg::REG_STAT2:      reg_read = {rating_reg.valid, rating_reg.second}; // [RQ8] [RQ9]
      lrb_pkg::REG_BLK_CTRL:   reg_read = blk_ctrl_reg;
      default:                 reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Class select: reserved and undefined classes pass only with all five bits set
  function automatic logic class_ok(input logic [7:0] f, input logic [2:0] c);
    if (c < lrb_pkg::CLS_RESERVED) begin
      class_ok = f[c];
    end else begin
      class_ok = (f[4:0] == 5'h1f);
    end
  endfunction : class_ok

  // Secondary filter on class and type
  function automatic logic sec_ok(input logic [2:0] s, input logic [2:0] c, input logic [6:0] t);
    unique case (s)
      lrb_pkg::SEC_ALL:    sec_ok = 1'b1;
      lrb_pkg::SEC_TIME:   sec_ok = (c == lrb_pkg::CLS_MISC) && (t == 7'h01 || t == 7'h04);
      lrb_pkg::SEC_INBAND: sec_ok = (c == lrb_pkg::CLS_CURRENT);
      lrb_pkg::SEC_RATING: sec_ok = (c == lrb_pkg::CLS_CURRENT) && (t == lrb_pkg::TYPE_RATING);
      lrb_pkg::SEC_VCR:    sec_ok = ((c == lrb_pkg::CLS_MISC) && (t == 7'h01 || t == 7'h04 || t == 7'h40))
                                 || ((c == lrb_pkg::CLS_CHANNEL) && (t >= 7'h01) && (t <= 7'h03))
                                 || ((c == lrb_pkg::CLS_CURRENT) && (t == 7'h08 || t == 7'h0d));
      default:             sec_ok = 1'b0;
    endcase
  endfunction : sec_ok

  // Does the captured rating hit an enabled mask bit
  function automatic logic rating_hit(input lrb_pkg::lrb_rating_t r, input logic [7:0] mm,
                                      input logic [7:0] mb, input logic [7:0] ms, input logic [7:0] md);
    logic [2:0] g;
    logic       hit;
    g   = r.second[2:0];
    hit = 1'b0;
    if (r.first[4:3] == lrb_pkg::SYS_TV) begin
      if (g >= 3'h1 && g <= 3'h6) begin
        hit = mb[g - 3'h1];                                               // [RQ1]
      end
      hit = hit | (r.second[4] & ((g == 3'h4 & ms[0]) | (g == 3'h5 & ms[1]) | (g == 3'h6 & ms[2]))); // [RQ2]
      hit = hit | (r.second[5] & ((g == 3'h2 & ms[4]) | (g == 3'h4 & ms[5])
                                 | (g == 3'h5 & ms[6]) | (g == 3'h6 & ms[7])));  // [RQ2]
      hit = hit | (r.first[5] & ((g == 3'h4 & md[0]) | (g == 3'h5 & md[1])));  // [RQ3]
      hit = hit | (r.second[3] & ((g == 3'h4 & md[4]) | (g == 3'h5 & md[5]) | (g == 3'h6 & md[6]))); // [RQ3]
    end else if (r.first[2:0] != 3'h0) begin
      hit = mm[r.first[2:0] - 3'h1];
    end
    rating_hit = r.valid & hit;                                           // [RQ4]
  endfunction : rating_hit

  // Pair decode; parity bit is dropped before classing
  always_comb begin
    c0          = i_l21_pair.b0[6:0];
    c1          = i_l21_pair.b1[6:0];
    is_xds_ctrl = (c0 >= lrb_pkg::XDS_CTRL_LO) && (c0 <= lrb_pkg::XDS_CTRL_HI);
    is_start    = is_xds_ctrl & c0[0];
    is_end      = (c0 == lrb_pkg::XDS_END);
    is_cc       = (c0 >= lrb_pkg::CC_CTRL_LO) && (c0 <= lrb_pkg::CC_CTRL_HI);
    sec_ctx     = 8'(c0 - 7'h01);
    cls_now     = sec_ctx[3:1];
    pass_now    = class_ok(filter_reg, cls_now)
                & sec_ok(filter_reg[7:lrb_pkg::FILT_SEC_LSB], cls_now, c1);  // [RQ13] [RQ22]
  end

  // Which pairs reach the output; the rating filter hides the start pair
  always_comb begin
    emit = 1'b0;
    if (is_start) begin
      emit = pass_now & (filter_reg[7:lrb_pkg::FILT_SEC_LSB] != lrb_pkg::SEC_RATING);
    end else if (is_xds_ctrl) begin
      emit = pass_reg & (cls_now == cls_reg);
    end else if (is_end) begin
      emit = in_xds_reg & pass_reg;
    end else if (!is_cc) begin
      emit = in_xds_reg & pass_reg;
    end
  end

  assign xds_load = i_l21_valid & i_l21_field2 & (filter_reg != 8'h00) & emit; // [RQ12] [RQ17]
  assign rate_cap = i_l21_valid & i_l21_field2 & in_xds_reg & rate_pkt_reg
                  & !is_xds_ctrl & !is_end & !is_cc;
  assign cmd_wr   = i_cmd_valid & (cmd_state_reg == lrb_pkg::CMD_WDATA);
  assign cmd_rds  = i_cmd_valid & (cmd_state_reg == lrb_pkg::CMD_IDLE)
                  & (i_cmd_byte[7:4] == lrb_pkg::CMD_RDS1 || i_cmd_byte[7:4] == lrb_pkg::CMD_RDS2);
  assign blk_en   = blk_ctrl_reg[lrb_pkg::BLK_EN_BIT];

  // Packet tracking across field-2 pairs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_xds_reg   <= 1'b0;
      pass_reg     <= 1'b0;
      cls_reg      <= 3'h0;
      rate_pkt_reg <= 1'b0;
    end else if (i_l21_valid && i_l21_field2) begin                  // [RQ12]
      if (is_start) begin
        in_xds_reg   <= 1'b1;
        pass_reg     <= pass_now;
        cls_reg      <= cls_now;
        rate_pkt_reg <= (cls_now == lrb_pkg::CLS_CURRENT) && (c1 == lrb_pkg::TYPE_RATING);
      end else if (is_xds_ctrl) begin
        in_xds_reg   <= 1'b1;
        pass_reg     <= pass_reg & (cls_now == cls_reg);
      end else if (is_end || is_cc) begin
        in_xds_reg   <= 1'b0;                                           // Captions interrupt the packet
        rate_pkt_reg <= rate_pkt_reg & is_cc;
      end else if (rate_cap) begin
        rate_pkt_reg <= 1'b0;                                           // Only the first data pair is the rating
      end
    end
  end

  // Command decoder: write carries one data byte, read-select is one byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_state_reg <= lrb_pkg::CMD_IDLE;
      wr_addr_reg   <= 4'h0;
    end else if (i_cmd_valid) begin
      unique case (cmd_state_reg)
        lrb_pkg::CMD_IDLE: begin
          if (i_cmd_byte[7:4] == lrb_pkg::CMD_WRITE) begin              // [RQ21]
            cmd_state_reg <= lrb_pkg::CMD_WDATA;
            wr_addr_reg   <= i_cmd_byte[3:0];
          end
        end
        lrb_pkg::CMD_WDATA: begin
          cmd_state_reg <= lrb_pkg::CMD_IDLE;
        end
      endcase
    end
  end

  // Writable registers; reserved mask bits are forced to zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      filter_reg     <= lrb_pkg::FILTER_RESET;                          // [RQ17]
      movie_mask_reg <= lrb_pkg::MASK_RESET;
      tv_base_reg    <= lrb_pkg::MASK_RESET;
      tv_sv_reg      <= lrb_pkg::MASK_RESET;
      tv_dl_reg      <= lrb_pkg::MASK_RESET;
      blk_ctrl_reg   <= lrb_pkg::BLK_RESET;
    end else if (cmd_wr) begin
      unique case (wr_addr_reg)
        lrb_pkg::REG_FILTER:     filter_reg     <= i_cmd_byte;          // [RQ21]
        lrb_pkg::REG_MOVIE_MASK: movie_mask_reg <= i_cmd_byte & lrb_pkg::MOVIE_MASK_BITS;
        lrb_pkg::REG_TV_BASE:    tv_base_reg    <= i_cmd_byte & lrb_pkg::TV_BASE_BITS; // [RQ1] [RQ5]
        lrb_pkg::REG_TV_SV:      tv_sv_reg      <= i_cmd_byte & lrb_pkg::TV_SV_BITS;   // [RQ2] [RQ5]
        lrb_pkg::REG_TV_DL:      tv_dl_reg      <= i_cmd_byte & lrb_pkg::TV_DL_BITS;   // [RQ3] [RQ5]
        lrb_pkg::REG_BLK_CTRL:   blk_ctrl_reg   <= i_cmd_byte;          // [RQ10] [RQ11]
        default:                 ;
      endcase
    end
  end

  // Rating capture; a new channel makes the old rating stale
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rating_reg <= '0;
    end else if (i_chan_change) begin
      rating_reg.valid <= 1'b0;                                         // [RQ9]
    end else if (rate_cap) begin
      rating_reg.first  <= c0;                                          // [RQ6]
      rating_reg.second <= c1;                                          // [RQ8]
      rating_reg.valid  <= 1'b1;                                        // [RQ9]
    end
  end

  // Match is registered so the status bit and the pin agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= rating_hit(rating_reg, movie_mask_reg, tv_base_reg, tv_sv_reg, tv_dl_reg); // [RQ7] [RQ23]
    end
  end

  // Extension counter: loaded on a channel change while blocking, one count per frame
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_cnt_reg <= 7'h00;
    end else if (i_chan_change && o_block) begin
      ext_cnt_reg <= blk_ctrl_reg[6:0];                                 // [RQ10]
    end else if (i_frame_tick && ext_cnt_reg != 7'h00) begin
      ext_cnt_reg <= ext_cnt_reg - 7'h01;                               // [RQ10]
    end
  end

  // Blocking pin; disabling the function drops it at once
  assign block_next = blk_en & (match_reg | (ext_cnt_reg != 7'h00));    // [RQ11] [RQ23]

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_block <= 1'b0;
    end else begin
      o_block <= block_next;                                            // [RQ1] [RQ4]
    end
  end

  // Output registers: a recovered pair beats a read-select in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out_byte0 <= 8'h00;
      o_out_byte1 <= 8'h00;
    end else if (xds_load) begin
      o_out_byte0 <= i_l21_pair.b0;                                     // [RQ14] [RQ16]
      o_out_byte1 <= i_l21_pair.b1;
    end else if (cmd_rds) begin                                         // Only read-select reloads [RQ20]
      o_out_byte0 <= reg_read(i_cmd_byte[3:0]);
      o_out_byte1 <= reg_read(4'(i_cmd_byte[3:0] + 4'h1));
    end
  end

  // Status flags; a load in the clearing cycle keeps them set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pair_ready_flag <= 1'b0;
      o_two_byte_flag   <= 1'b0;
    end else if (xds_load) begin
      o_pair_ready_flag <= 1'b1;                                        // [RQ15]
      o_two_byte_flag   <= 1'b1;                                        // [RQ15]
    end else if (cmd_rds) begin
      o_pair_ready_flag <= 1'b1;
      o_two_byte_flag   <= (i_cmd_byte[7:4] == lrb_pkg::CMD_RDS2);
    end else if (i_out_read) begin
      o_pair_ready_flag <= 1'b0;
      o_two_byte_flag   <= 1'b0;
    end
  end

  // Assertions
  sequence ext_load_s;
    i_chan_change && o_block && blk_en && blk_ctrl_reg[6:0] != 7'h00 && !cmd_wr;
  endsequence

  sequence ext_hold_s;
    ##2 o_block;
  endsequence

  block_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !blk_en |=> !o_block) else $error("blocking pin high while disabled"); // [RQ11]

  block_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
    blk_en && match_reg |=> o_block) else $error("enabled match did not block"); // [RQ1]

  block_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_block |-> $past(blk_en) && ($past(match_reg) || $past(ext_cnt_reg) != 7'h00))
    else $error("blocking pin high without cause"); // [RQ4]

  ext_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ext_load_s |-> ext_hold_s) else $error("extension did not hold blocking"); // [RQ10]

  field_even_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ12]
    !$past(cmd_rds) && ($changed(o_out_byte0) || $changed(o_out_byte1))
    |-> $past(i_l21_valid && i_l21_field2 && filter_reg != 8'h00))
    else $error("output changed without even-field pair");

  load_flags_a: assert property (@(posedge i_clk) disable iff (i_rst)
    xds_load |=> o_pair_ready_flag && o_two_byte_flag && o_out_byte0 == $past(i_l21_pair.b0)
                 && o_out_byte1 == $past(i_l21_pair.b1)) else $error("pair load flags or data wrong"); // [RQ15]

  cmd_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_wr && !xds_load |=> $stable(o_out_byte0) && $stable(o_out_byte1))
    else $error("write command disturbed output registers"); // [RQ20]

  rating_cap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rate_cap && !i_chan_change |=> rating_reg.valid && rating_reg.first == $past(c0)
                 && rating_reg.second == $past(c1)) else $error("rating capture wrong"); // [RQ6]

  stale_rating_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_chan_change |=> !rating_reg.valid ##1 !match_reg) else $error("stale rating still valid"); // [RQ9]

endmodule : lrb_top

/* rtl/lrb_pkg.sv */
// Package of constants and carrier types for the rating blocking and data recovery block
// Function
// RQ1 - Base TV mask bit set blocks matching rating
// RQ2 - Sexual/fantasy/violence variant masks block matching rating
// RQ3 - Dialogue and language variant masks block matching rating
// RQ4 - Cleared mask bit never raises blocking output
// RQ5 - Host writes zero to reserved mask bits
// RQ6 - First status shows first rating byte
// RQ7 - First status bit 7 shows blocking match
// RQ8 - Second status shows second rating byte
// RQ9 - Second status bit 7 shows rating valid
// RQ10 - Extension field prolongs blocking per frame
// RQ11 - Control bit 7 enables program blocking
// RQ12 - Extended data taken from even field only
// RQ13 - Class bits enable recovery, secondary code restricts
// RQ14 - Filtered pairs loaded at once, in order
// RQ15 - Loading sets pair-ready and two-byte flags
// RQ16 - Recovered pair readable without read-select
// RQ17 - Filter resets zero; zero disables recovery
// RQ18 - Host avoids other reads early in field 2
// RQ19 - Host reads at field end or blanking
// RQ20 - Non read-select commands leave recovery alone
// RQ21 - Write command C5 plus code sets filter
// RQ22 - Filter bits: five classes, three-bit secondary
// RQ23 - Output ORs enabled matches, gated, extended
package lrb_pkg;

  // Register addresses
  localparam logic [3:0] REG_FILTER     = 4'h5;
  localparam logic [3:0] REG_MOVIE_MASK = 4'h6;
  localparam logic [3:0] REG_TV_BASE    = 4'h9;
  localparam logic [3:0] REG_TV_SV      = 4'ha;
  localparam logic [3:0] REG_TV_DL      = 4'hb;
  localparam logic [3:0] REG_STAT1      = 4'hc;
  localparam logic [3:0] REG_STAT2      = 4'hd;
  localparam logic [3:0] REG_BLK_CTRL   = 4'he;

  // Writable bits of each mask; reserved bits store and read as zero
  localparam logic [7:0] MOVIE_MASK_BITS = 8'h7f;
  localparam logic [7:0] TV_BASE_BITS    = 8'h3f;
  localparam logic [7:0] TV_SV_BITS      = 8'hf7;
  localparam logic [7:0] TV_DL_BITS      = 8'h73;

  // Values after reset
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] BLK_RESET    = 8'h00;

  // Field positions
  localparam int BLK_EN_BIT    = 7;
  localparam int FILT_SEC_LSB  = 5;
  localparam int STAT_FLAG_BIT = 7;

  // Command upper nibbles
  localparam logic [3:0] CMD_WRITE = 4'hc;
  localparam logic [3:0] CMD_RDS1  = 4'h4;
  localparam logic [3:0] CMD_RDS2  = 4'h6;

  // Extended data control codes and classes
  localparam logic [6:0] XDS_CTRL_LO  = 7'h01;
  localparam logic [6:0] XDS_CTRL_HI  = 7'h0e;
  localparam logic [6:0] XDS_END      = 7'h0f;
  localparam logic [6:0] CC_CTRL_LO   = 7'h10;
  localparam logic [6:0] CC_CTRL_HI   = 7'h1f;
  localparam logic [2:0] CLS_CURRENT  = 3'h0;
  localparam logic [2:0] CLS_CHANNEL  = 3'h2;
  localparam logic [2:0] CLS_MISC     = 3'h3;
  localparam logic [2:0] CLS_RESERVED = 3'h5;
  localparam logic [6:0] TYPE_RATING  = 7'h05;
  localparam logic [1:0] SYS_TV       = 2'h1;

  // Secondary filter codes
  localparam logic [2:0] SEC_ALL    = 3'h0;
  localparam logic [2:0] SEC_TIME   = 3'h1;
  localparam logic [2:0] SEC_INBAND = 3'h2;
  localparam logic [2:0] SEC_RATING = 3'h3;
  localparam logic [2:0] SEC_VCR    = 3'h4;

  // Byte pair from the slicer
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
  } lrb_pair_t;

  // Captured rating
  typedef struct packed {
    logic       valid;
    logic [6:0] first;
    logic [6:0] second;
  } lrb_rating_t;

  typedef enum logic {CMD_IDLE, CMD_WDATA} lrb_cmd_state_t;

endpackage : lrb_pkg

/* testbench/lrb_host_model.sv */
// Host processor model: serial commands, register writes and pair reads
`timescale 1ns/1ps
module lrb_host_model (
  // Clock
  input  wire logic       i_clk,
  // Output register of the block
  input  wire logic [7:0] i_out_byte0,
  // Command side
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_byte,
  output logic            o_out_read
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'h00;
    o_out_read  = 1'b0;
  end

  // One command byte, launched just after an edge
  task automatic put(input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_byte  = b;
  endtask : put

  // Released byte flips so a stale value is never mistaken for data
  task automatic idle();
    @(posedge i_clk);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_byte  = ~o_cmd_byte;
  endtask : idle

  // Write command then data, reserved bits kept low
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d, input logic [7:0] keep);
    put({lrb_pkg::CMD_WRITE, a});
    put(d & keep);
    idle();
  endtask : write_reg

  // Done outside the start of field 2 only, as the host schedules it
  task automatic take();
    @(posedge i_clk);
    #1 o_out_read = 1'b1;
    @(posedge i_clk);
    #1 o_out_read = 1'b0;
  endtask : take

  // One-byte read-select, take the byte, then release the flags
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    put({lrb_pkg::CMD_RDS1, a});
    idle();
    d = i_out_byte0;
    take();
  endtask : read_reg
endmodule : lrb_host_model

/* testbench/tb_top.sv */
// Self-checking bench for rating blocking and extended data recovery
`timescale 1ns/1ps
module tb_top;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_l21_valid = 1'b0;
  logic              i_l21_field2 = 1'b0;
  lrb_pkg::lrb_pair_t i_l21_pair = '0;
  logic              i_frame_tick = 1'b0;
  logic              i_chan_change = 1'b0;
  logic              i_cmd_valid;
  logic        [7:0] i_cmd_byte;
  logic              i_out_read;
  logic        [7:0] o_out_byte0;
  logic        [7:0] o_out_byte1;
  logic              o_pair_ready_flag;
  logic              o_two_byte_flag;
  logic              o_block;
  logic        [7:0] d;
  logic        [7:0] m;
  logic        [2:0] g;
  logic              en;
  int                fail_count = 0;
  int                total_checks = 0;
  // Content variant cases: mask register, bit, rating bytes
  logic        [3:0] c_reg [5] = '{4'ha, 4'ha, 4'ha, 4'hb, 4'hb};
  logic        [2:0] c_bit [5] = '{3'd0, 3'd4, 3'd7, 3'd0, 3'd6};
  logic        [7:0] c_b1  [5] = '{8'h48, 8'h48, 8'h48, 8'h68, 8'h48};
  logic        [7:0] c_b2  [5] = '{8'h54, 8'h62, 8'h66, 8'h44, 8'h4e};
  logic        [7:0] codes [6] = '{8'h41, 8'h61, 8'h01, 8'h28, 8'h9f, 8'h1f};
  logic        [3:0] r_adr [4] = '{4'h9, 4'ha, 4'hb, 4'he};
  logic        [7:0] r_keep[4] = '{8'h3f, 8'hf7, 8'h73, 8'hff};

  lrb_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_l21_valid(i_l21_valid), .i_l21_field2(i_l21_field2),
    .i_l21_pair(i_l21_pair), .i_frame_tick(i_frame_tick), .i_chan_change(i_chan_change),
    .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte), .i_out_read(i_out_read),
    .o_out_byte0(o_out_byte0), .o_out_byte1(o_out_byte1), .o_pair_ready_flag(o_pair_ready_flag),
    .o_two_byte_flag(o_two_byte_flag), .o_block(o_block));

  lrb_host_model uhost (.i_clk(i_clk), .i_out_byte0(o_out_byte0), .o_cmd_valid(i_cmd_valid),
    .o_cmd_byte(i_cmd_byte), .o_out_read(i_out_read));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // Status byte 2 expected for a plain TV rating of level g
  function automatic logic [7:0] stat2_exp(input logic [2:0] lvl);
    return {1'b1, 4'h8, lvl};
  endfunction : stat2_exp

  // One slicer pair; released pair flips so old data is not reused
  task automatic pair(input logic f2, input logic [7:0] b0, input logic [7:0] b1);
    @(posedge i_clk);
    #1 {i_l21_valid, i_l21_field2, i_l21_pair} = {1'b1, f2, b0, b1};
    @(posedge i_clk);
    #1 i_l21_valid = 1'b0;
    i_l21_pair = ~i_l21_pair;
  endtask : pair

  task automatic settle();
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle

  // Start pair then rating data pair in the even field
  task automatic rating(input logic [7:0] b1, input logic [7:0] b2);
    pair(1'b1, 8'h01, 8'h05);
    pair(1'b1, b1, b2);
    settle();
  endtask : rating

  // Frame tick (c=0) or channel change (c=1) pulse
  task automatic ev(input logic c);
    @(posedge i_clk);
    #1 {i_chan_change, i_frame_tick} = {c, ~c};
    @(posedge i_clk);
    #1 {i_chan_change, i_frame_tick} = 2'b00;
    settle();
  endtask : ev

  // Hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(41));
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'b0;
    check_bit(o_block, 1'b0);
    check_bit(o_pair_ready_flag, 1'b0);
    // Reset values, then masked read-back of the three TV masks and the blocking control
    uhost.read_reg(lrb_pkg::REG_FILTER, d);
    check_byte(d, 8'h00);
    for (int k = 0; k < 4; k++) begin
      uhost.read_reg(r_adr[k], d);
      check_byte(d, 8'h00);
      m = 8'($urandom);
      uhost.write_reg(r_adr[k], m, r_keep[k]);
      uhost.read_reg(r_adr[k], d);
      check_byte(d, m & r_keep[k]);
    end
    // Random base ratings against random masks and enable
    for (int n = 0; n < 12; n++) begin
      g = 3'($urandom_range(6, 1));
      m = 8'($urandom);
      en = 1'($urandom);
      uhost.write_reg(lrb_pkg::REG_TV_BASE, m, lrb_pkg::TV_BASE_BITS);
      uhost.write_reg(lrb_pkg::REG_BLK_CTRL, {en, 7'h00}, 8'hff);
      rating(8'h48, {5'h08, g});
      check_bit(o_block, en & m[g-1]);
      check_bit(o_pair_ready_flag, 1'b0);
      uhost.put(8'h6c);
      uhost.idle();
      check_byte(o_out_byte0, {m[g-1], 7'h48});
      check_byte(o_out_byte1, stat2_exp(g));
      check_bit(o_two_byte_flag, 1'b1);
      uhost.take();
    end
    // Content variants block with base mask clear, unblock when cleared
    uhost.write_reg(lrb_pkg::REG_TV_BASE, 8'h00, 8'hff);
    uhost.write_reg(lrb_pkg::REG_BLK_CTRL, 8'h80, 8'hff);
    for (int k = 0; k < 5; k++) begin
      uhost.write_reg(c_reg[k], 8'h01 << c_bit[k], 8'hff);
      rating(c_b1[k], c_b2[k]);
      check_bit(o_block, 1'b1);
      uhost.write_reg(c_reg[k], 8'h00, 8'hff);
      settle();
      check_bit(o_block, 1'b0);
    end
    // Channel change during blocking holds the pin for three frames
    uhost.write_reg(lrb_pkg::REG_TV_BASE, 8'h20, 8'hff);
    uhost.write_reg(lrb_pkg::REG_BLK_CTRL, 8'h83, 8'hff);
    rating(8'h48, 8'h46);
    ev(1'b1);
    for (int t = 0; t < 3; t++) begin
      check_bit(o_block, 1'b1);
      ev(1'b0);
    end
    check_bit(o_block, 1'b0);
    uhost.read_reg(lrb_pkg::REG_STAT2, d);
    check_bit(d[7], 1'b0);
    // Rating filter: odd field and start pair withheld, data and end pass
    uhost.write_reg(lrb_pkg::REG_FILTER, 8'h61, 8'hff);
    pair(1'b0, 8'h01, 8'h05);
    pair(1'b0, 8'h48, 8'h44);
    pair(1'b1, 8'h01, 8'h05);
    settle();
    check_bit(o_pair_ready_flag, 1'b0);
    pair(1'b1, 8'h48, 8'h43);
    settle();
    check_byte(o_out_byte0, 8'h48);
    check_byte(o_out_byte1, 8'h43);
    check_bit(o_pair_ready_flag & o_two_byte_flag, 1'b1);
    fork
      uhost.put(8'h10);
      pair(1'b1, 8'h0f, 8'h2a);
    join
    uhost.idle();
    settle();
    check_byte({o_out_byte0[3:0], o_out_byte1[3:0]}, 8'hfa);
    uhost.take();
    // Every documented filter code stores as written
    for (int k = 0; k < 6; k++) begin
      uhost.write_reg(lrb_pkg::REG_FILTER, codes[k], 8'hff);
      uhost.read_reg(lrb_pkg::REG_FILTER, d);
      check_byte(d, codes[k]);
    end
    pair(1'b1, 8'h01, 8'h05);
    settle();
    check_byte(o_out_byte0, 8'h01);
    uhost.take();
    // Time filter: current start withheld, misc start and its continue pass
    uhost.write_reg(lrb_pkg::REG_FILTER, 8'h28, 8'hff);
    pair(1'b1, 8'h01, 8'h05);
    settle();
    check_bit(o_pair_ready_flag, 1'b0);
    pair(1'b1, 8'h07, 8'h01);
    settle();
    check_byte(o_out_byte0, 8'h07);
    check_bit(o_pair_ready_flag, 1'b1);
    pair(1'b1, 8'h08, 8'h01);
    settle();
    check_byte(o_out_byte0, 8'h08);
    uhost.take();
    uhost.write_reg(lrb_pkg::REG_FILTER, 8'h00, 8'hff);
    pair(1'b1, 8'h01, 8'h05);
    settle();
    check_bit(o_pair_ready_flag, 1'b0);
    // Movie system rating indexes the movie mask; disable drops the pin
    uhost.write_reg(lrb_pkg::REG_MOVIE_MASK, 8'h04, 8'hff);
    rating(8'h43, 8'h40);
    check_bit(o_block, 1'b1);
    uhost.write_reg(lrb_pkg::REG_BLK_CTRL, 8'h00, 8'hff);
    settle();
    check_bit(o_block, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
